// File: logic/lcdmc_top.v
// Display mode control: APB registers, mode decode, output gating and clock options.
//
// How it works
// - Slice field codes 0..5 mean static, 2, 3, 4, 6, 8 slices; rest prohibited.
// - Bias field 00 half, 01 third, 10 quarter; 11 prohibited.
// - Primary mode register resets to zero and is read-write.
// - Secondary mode register resets to zero and is bit or byte writable.
// - Output off grounds pins; display off deselects segments; both on displays.
// - Boost enable starts the boost or capacitor split circuit, clear stops it.
// - Without blink, nibble select picks lower or upper data nibble.
// - With blink, nibbles alternate at each fixed-cycle tick from the clock.
// - Low-power gate stops sub clock to other peripherals in stop or halt while the CPU runs on the sub clock.
// - Clock source bit picks sub clock or low-speed oscillator for the display.
// - Subclock supply option register resets to zero and is bit or byte writable.
// - Generator field 00 resistor, 01 boosting, 10 capacitor split; 11 prohibited.
// - Waveform bit selects waveform A at zero and waveform B at one.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "lcdmc_consts.vh"
module lcdmc_top #(
  parameter ADDR_W = 22
) (
  // Clock and reset.
  input  wire              ref_clk,
  input  wire              rst_b,
  // APB slave.
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire              pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  // System state for clock gating.
  input  wire              cpu_on_subclk,
  input  wire              stop_or_halt,
  // Blink timing and display data.
  input  wire              rtc_fixed_cycle_interrupt,
  input  wire [7:0]        disp_byte,
  // Decoded drive mode.
  output reg               waveform_b,
  output reg  [3:0]        com_count,
  output reg  [2:0]        bias_onehot,
  output reg  [2:0]        gen_onehot,
  output reg               config_error,
  // Pin and circuit control.
  output reg               pins_grounded,
  output reg               segments_deselected,
  output reg               display_active,
  output reg               boost_circuit_run,
  output reg               boost_pin_init,
  output reg  [3:0]        disp_nibble,
  // Clock options.
  output reg               periph_subclk_en,
  output reg               lcd_clk_lowspeed
);

  // Register array indexes, widened to byte addresses.
  localparam [ADDR_W-1:0] A_OPT = {`LCDMC_IDX_OPTION, 2'b00};
  localparam [ADDR_W-1:0] A_PRI = {`LCDMC_IDX_PRIMARY, 2'b00};
  localparam [ADDR_W-1:0] A_SEC = {`LCDMC_IDX_SECONDARY, 2'b00};
  localparam [ADDR_W-1:0] A_STA = {`LCDMC_IDX_STATUS, 2'b00};

  // Slot numbers of the three software-written registers and the read-only status word.
  localparam [1:0] R_OPT = 2'd0;
  localparam [1:0] R_PRI = 2'd1;
  localparam [1:0] R_SEC = 2'd2;
  localparam [1:0] R_STA = 2'd3;

  reg  [7:0] opt_reg;
  reg  [7:0] pri_reg;
  reg  [7:0] sec_reg;
  wire       show_upper;

  // Field views of the primary mode register.
  wire [1:0] gen_code   = pri_reg[`LCDMC_P_GEN_HI:`LCDMC_P_GEN_LO];
  wire [2:0] slice_code = pri_reg[`LCDMC_P_SLICE_HI:`LCDMC_P_SLICE_LO];
  wire [1:0] bias_code  = pri_reg[`LCDMC_P_BIAS_HI:`LCDMC_P_BIAS_LO];
  wire       wave_bit   = pri_reg[`LCDMC_P_WAVE];

  // Field views of the secondary mode and option registers.
  wire disp_on  = sec_reg[`LCDMC_S_DISP_ON];
  wire seg_oe   = sec_reg[`LCDMC_S_SEG_OE];
  wire boost_en = sec_reg[`LCDMC_S_BOOST_EN];
  wire blink_en = sec_reg[`LCDMC_S_BLINK];
  wire nib_sel  = sec_reg[`LCDMC_S_NIBBLE];
  wire pin_init = sec_reg[`LCDMC_S_PIN_INIT];
  wire lp_gate  = opt_reg[`LCDMC_O_LP_GATE];
  wire src_sel  = opt_reg[`LCDMC_O_SRC_SEL];

  // Maps a byte address to a register slot; bit 2 flags a hit.
  function [2:0] decode_addr;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        A_OPT:   decode_addr = {1'b1, R_OPT};
        A_PRI:   decode_addr = {1'b1, R_PRI};
        A_SEC:   decode_addr = {1'b1, R_SEC};
        A_STA:   decode_addr = {1'b1, R_STA};
        default: decode_addr = 3'h0;
      endcase
    end
  endfunction

  // Number of common lines for a slice code, zero when prohibited.
  function [3:0] slices_of;
    input [2:0] s;
    begin
      case (s)
        `LCDMC_SL_STATIC: slices_of = 4'h1;
        `LCDMC_SL_2:      slices_of = 4'h2;
        `LCDMC_SL_3:      slices_of = 4'h3;
        `LCDMC_SL_4:      slices_of = 4'h4;
        `LCDMC_SL_6:      slices_of = 4'h6;
        `LCDMC_SL_8:      slices_of = 4'h8;
        default:          slices_of = 4'h0;
      endcase
    end
  endfunction

  // Two-bit code to one-hot, zero for the prohibited code 11.
  function [2:0] onehot3;
    input [1:0] c;
    begin
      case (c)
        2'h0:    onehot3 = 3'h1;
        2'h1:    onehot3 = 3'h2;
        2'h2:    onehot3 = 3'h4;
        default: onehot3 = 3'h0;
      endcase
    end
  endfunction

  // True when waveform, slices, bias and generator form a supported set.
  function combo_ok;
    input       w;
    input [2:0] s;
    input [1:0] b;
    input [1:0] g;
    reg         res;
    reg         boost;
    reg         cap;
    begin
      res   = (g == `LCDMC_GN_RES);
      boost = (g == `LCDMC_GN_BOOST);
      cap   = (g == `LCDMC_GN_CAP);
      combo_ok = 1'b0;
      if (b == `LCDMC_BI_THIRD) begin
        // Third bias runs on every generator with 3, 4, 6 or 8 slices.
        combo_ok = (s == `LCDMC_SL_3) || (s == `LCDMC_SL_4) ||
                   (s == `LCDMC_SL_6) || (s == `LCDMC_SL_8);
      end else if (b == `LCDMC_BI_QUARTER) begin
        // Quarter bias never with capacitor split; six slices only for A boosting.
        combo_ok = ((s == `LCDMC_SL_8) && (res || boost)) ||
                   ((s == `LCDMC_SL_6) && boost && !w);
      end else if (b == `LCDMC_BI_HALF) begin
        // Half bias and static are waveform A with resistor division only.
        combo_ok = !w && res &&
                   ((s == `LCDMC_SL_STATIC) || (s == `LCDMC_SL_2) ||
                    (s == `LCDMC_SL_3));
      end
    end
  endfunction

  // Access phase of an APB transfer.
  wire       acc       = psel && penable;
  wire [2:0] wr_dec    = decode_addr(paddr);
  wire       wr_lane0  = acc && pwrite && pstrb[0] && wr_dec[2];
  wire       st_ok     = combo_ok(wave_bit, slice_code, bias_code, gen_code);
  wire [7:0] status_rd = {1'b0, boost_circuit_run, pins_grounded, show_upper,
                          (gen_code == 2'h3), (bias_code == 2'h3),
                          (slices_of(slice_code) == 4'h0), st_ok};

  // The slave answers every access in its first access cycle.
  assign pready = 1'b1;

  // Register writes; only implemented bits are stored, reserved ones stay zero.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_reg <= `LCDMC_RST_OPTION;
      pri_reg <= `LCDMC_RST_PRIMARY;
      sec_reg <= `LCDMC_RST_SECONDARY;
    end else if (wr_lane0) begin
      case (wr_dec[1:0])
        R_OPT: begin
          opt_reg <= pwdata[7:0] & `LCDMC_O_MASK;
        end
        R_PRI: begin
          // No write guard: software must not rewrite it with outputs on.
          pri_reg <= pwdata[7:0];
        end
        R_SEC: begin
          sec_reg <= pwdata[7:0] & `LCDMC_S_MASK;
        end
        default: begin
          // The status word is read-only; writes to it are dropped.
          opt_reg <= opt_reg;
        end
      endcase
    end
  end

  // Read data and error are captured in the setup cycle, so both stand
  // from flip-flops throughout the single access cycle.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !wr_dec[2];
      if (pwrite || !wr_dec[2]) begin
        prdata <= 32'h0000_0000;
      end else begin
        case (wr_dec[1:0])
          R_OPT:   prdata <= {24'h00_0000, opt_reg};
          R_PRI:   prdata <= {24'h00_0000, pri_reg};
          R_SEC:   prdata <= {24'h00_0000, sec_reg};
          default: prdata <= {24'h00_0000, status_rd};
        endcase
      end
    end
  end

  // Drive mode decode toward the waveform generator.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waveform_b   <= 1'b0;
      com_count    <= 4'h1;
      bias_onehot  <= 3'h1;
      gen_onehot   <= 3'h1;
      config_error <= 1'b0;
    end else begin
      waveform_b   <= wave_bit;
      com_count    <= slices_of(slice_code);
      bias_onehot  <= onehot3(bias_code);
      gen_onehot   <= onehot3(gen_code);
      // Unsupported sets are flagged, not corrected: the panel may still be
      // driven, but its behaviour is then undefined. Static with a nonzero
      // bias and every unlisted combination land here.
      config_error <= !st_ok;
    end
  end

  // Pin gating and the boost or capacitor split circuit.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_grounded       <= 1'b1;
      segments_deselected <= 1'b0;
      display_active      <= 1'b0;
      boost_circuit_run   <= 1'b0;
      boost_pin_init      <= 1'b0;
    end else begin
      pins_grounded       <= !seg_oe;
      segments_deselected <= seg_oe && !disp_on;
      display_active      <= seg_oe && disp_on;
      // Resistor division has no circuit to start, so the bit is ignored then.
      boost_circuit_run   <= boost_en && (gen_code == `LCDMC_GN_BOOST ||
                                          gen_code == `LCDMC_GN_CAP);
      boost_pin_init      <= pin_init;
    end
  end

  // Phase of the nibble choice, including blinking.
  lcdmc_blink u_blink (
    .ref_clk                   (ref_clk),
    .rst_b                     (rst_b),
    .blink_enable              (blink_en),
    .nibble_select             (nib_sel),
    .rtc_fixed_cycle_interrupt (rtc_fixed_cycle_interrupt),
    .show_upper                (show_upper)
  );

  // Displayed nibble of the current data byte.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      disp_nibble <= 4'h0;
    end else if (show_upper) begin
      disp_nibble <= disp_byte[7:4];
    end else begin
      disp_nibble <= disp_byte[3:0];
    end
  end

  // Clock supply options. The display keeps its clock in low-power states;
  // only the other peripherals lose the sub clock.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_subclk_en <= 1'b1;
      lcd_clk_lowspeed <= 1'b0;
    end else begin
      periph_subclk_en <= !(lp_gate && stop_or_halt && cpu_on_subclk);
      lcd_clk_lowspeed <= src_sel;
    end
  end

endmodule // lcdmc_top

// File: logic/lcdmc_consts.vh
// Register indexes, field positions and reset values of the display mode control block.
`ifndef LCDMC_CONSTS_VH
`define LCDMC_CONSTS_VH

// Register indexes; the byte address on the bus is four times the index.
`define LCDMC_IDX_OPTION     20'hF00F3
`define LCDMC_IDX_PRIMARY    20'hFFF40
`define LCDMC_IDX_SECONDARY  20'hFFF41
`define LCDMC_IDX_STATUS     20'hFFF4C

// Reset values.
`define LCDMC_RST_OPTION     8'h00
`define LCDMC_RST_PRIMARY    8'h00
`define LCDMC_RST_SECONDARY  8'h00

// Primary mode register fields.
`define LCDMC_P_GEN_HI       7
`define LCDMC_P_GEN_LO       6
`define LCDMC_P_WAVE         5
`define LCDMC_P_SLICE_HI     4
`define LCDMC_P_SLICE_LO     2
`define LCDMC_P_BIAS_HI      1
`define LCDMC_P_BIAS_LO      0

// Secondary mode register fields; bits 2 and 0 are reserved.
`define LCDMC_S_DISP_ON      7
`define LCDMC_S_SEG_OE       6
`define LCDMC_S_BOOST_EN     5
`define LCDMC_S_BLINK        4
`define LCDMC_S_NIBBLE       3
`define LCDMC_S_PIN_INIT     1
`define LCDMC_S_MASK         8'hFA

// Subclock supply option fields; other bits are reserved.
`define LCDMC_O_LP_GATE      7
`define LCDMC_O_SRC_SEL      4
`define LCDMC_O_MASK         8'h90

// Slice count codes.
`define LCDMC_SL_STATIC      3'h0
`define LCDMC_SL_2           3'h1
`define LCDMC_SL_3           3'h2
`define LCDMC_SL_4           3'h3
`define LCDMC_SL_6           3'h4
`define LCDMC_SL_8           3'h5

// Bias codes.
`define LCDMC_BI_HALF        2'h0
`define LCDMC_BI_THIRD       2'h1
`define LCDMC_BI_QUARTER     2'h2

// Drive generator codes.
`define LCDMC_GN_RES         2'h0
`define LCDMC_GN_BOOST       2'h1
`define LCDMC_GN_CAP         2'h2

`endif

// File: logic/lcdmc_blink.v
// Blink phase tracker that picks the displayed nibble of each display data byte.
`timescale 1ns/1ps
module lcdmc_blink (
  // Clock and reset.
  input  wire       ref_clk,
  input  wire       rst_b,
  // Control.
  input  wire       blink_enable,
  input  wire       nibble_select,
  input  wire       rtc_fixed_cycle_interrupt,
  // Result.
  output reg        show_upper
);

  localparam [1:0] ST_A = 2'b01;
  localparam [1:0] ST_B = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  // Next phase: flips on each fixed-cycle tick, parks on A while blink is off.
  always @* begin
    next_state = state;
    case (state)
      ST_A: begin
        if (blink_enable && rtc_fixed_cycle_interrupt) begin
          next_state = ST_B;
        end
      end
      ST_B: begin
        if (!blink_enable) begin
          next_state = ST_A;
        end else if (rtc_fixed_cycle_interrupt) begin
          next_state = ST_A;
        end
      end
      default: begin
        next_state = ST_A;
      end
    endcase
  end

  // Phase register and the nibble choice it drives.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_A;
      show_upper <= 1'b0;
    end else begin
      state <= next_state;
      if (blink_enable) begin
        show_upper <= (next_state == ST_B);
      end else begin
        show_upper <= nibble_select;
      end
    end
  end

endmodule // lcdmc_blink

// File: tb/lcdmc_checker.sv
// Checker that watches the ports of the display mode control block.
`timescale 1ns/1ps
`include "lcdmc_consts.vh"
module lcdmc_checker #(
  parameter ADDR_W = 22
) (
  // Clock and reset.
  input wire              ref_clk,
  input wire              rst_b,
  // APB.
  input wire              psel,
  input wire              penable,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pslverr,
  // System state and data.
  input wire              cpu_on_subclk,
  input wire              stop_or_halt,
  input wire [7:0]        disp_byte,
  // Decoded outputs.
  input wire [3:0]        com_count,
  input wire [2:0]        bias_onehot,
  input wire [2:0]        gen_onehot,
  input wire              pins_grounded,
  input wire              segments_deselected,
  input wire              display_active,
  input wire              boost_circuit_run,
  input wire              periph_subclk_en,
  input wire [3:0]        disp_nibble
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // The status word is mapped too, so it is not refused.
  wire mapped = paddr == {`LCDMC_IDX_OPTION, 2'h0} || paddr == {`LCDMC_IDX_PRIMARY, 2'h0}
    || paddr == {`LCDMC_IDX_SECONDARY, 2'h0} || paddr == {`LCDMC_IDX_STATUS, 2'h0};
  // The two phases of one APB transfer.
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  unmapped_refused_a: assert property ((apb_setup ##0 !mapped) ##1 apb_access
    |-> pslverr && prdata == 32'h0) else $error("Unmapped access not refused.");
  mapped_accepted_a: assert property ((apb_setup ##0 mapped) ##1 apb_access
    |-> !pslverr) else $error("Mapped access refused.");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("Read data above bit 7 not zero.");
  slice_decode_a: assert property (com_count inside {0, 1, 2, 3, 4, 6, 8})
    else $error("Common count outside the slice table.");
  bias_decode_a: assert property ($onehot0(bias_onehot))
    else $error("More than one bias selected.");
  gen_decode_a: assert property ($onehot0(gen_onehot))
    else $error("More than one generator selected.");
  pin_state_a: assert property ($onehot({pins_grounded, segments_deselected, display_active}))
    else $error("Pin state not exactly one of three.");
  boost_gen_a: assert property (boost_circuit_run |-> gen_onehot[1] || gen_onehot[2])
    else $error("Boost runs with resistor division.");
  subclk_gate_a: assert property ($past(rst_b) && !periph_subclk_en
    |-> $past(stop_or_halt && cpu_on_subclk)) else $error("Sub clock gated out of mode.");
  nibble_source_a: assert property ($past(rst_b) |-> disp_nibble == $past(disp_byte[3:0])
    || disp_nibble == $past(disp_byte[7:4])) else $error("Shown nibble not from data.");
endmodule // lcdmc_checker

bind lcdmc_top lcdmc_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst_b, .psel, .penable,
  .paddr, .prdata, .pslverr, .cpu_on_subclk, .stop_or_halt, .disp_byte, .com_count,
  .bias_onehot, .gen_onehot, .pins_grounded, .segments_deselected, .display_active,
  .boost_circuit_run, .periph_subclk_en, .disp_nibble);

// File: tb/lcdmc_panel.sv
// Passive glass model that shows what the drive outputs would make visible.
`timescale 1ns/1ps
module lcdmc_panel (
  // Drive state.
  input  wire       pins_grounded,
  input  wire       display_active,
  input  wire [3:0] disp_nibble,
  // What the glass shows.
  output reg  [3:0] seen
);
  // Glass is passive, so grounded or deselected pins leave every segment dark.
  always @* begin
    seen = (display_active && !pins_grounded) ? disp_nibble : 4'h0;
  end
endmodule // lcdmc_panel

// File: tb/test_lcd_drive_mode_control.sv
// Self-checking bench for the display mode control block.
`timescale 1ns/1ps
`include "lcdmc_consts.vh"
module test_lcd_drive_mode_control;
  localparam [21:0] A_OPT = {`LCDMC_IDX_OPTION, 2'h0};
  localparam [21:0] A_PRI = {`LCDMC_IDX_PRIMARY, 2'h0};
  localparam [21:0] A_SEC = {`LCDMC_IDX_SECONDARY, 2'h0};
  localparam [31:0] COMS  = 32'h00864321;
  // Bench-driven inputs.
  reg         ref_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [21:0] paddr = 22'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [3:0]  pstrb = 4'h0;
  reg         cpu_on_subclk = 1'b0;
  reg         stop_or_halt = 1'b0;
  reg         rtc_fixed_cycle_interrupt = 1'b0;
  reg  [7:0]  disp_byte = 8'h5A;
  // Design outputs and bench state.
  wire        pready, pslverr, waveform_b, config_error, pins_grounded;
  wire        segments_deselected, display_active, boost_circuit_run, boost_pin_init;
  wire        periph_subclk_en, lcd_clk_lowspeed;
  wire [31:0] prdata;
  wire [3:0]  com_count, disp_nibble, seen;
  wire [2:0]  bias_onehot, gen_onehot;
  integer     err_total = 0;
  integer     checks_done = 0;
  reg  [31:0] rdat;
  reg         rerr;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  lcdmc_top dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .cpu_on_subclk, .stop_or_halt, .rtc_fixed_cycle_interrupt,
    .disp_byte, .waveform_b, .com_count, .bias_onehot, .gen_onehot, .config_error,
    .pins_grounded, .segments_deselected, .display_active, .boost_circuit_run,
    .boost_pin_init, .disp_nibble, .periph_subclk_en, .lcd_clk_lowspeed);
  lcdmc_panel u_panel (.pins_grounded, .display_active, .disp_nibble, .seen);

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task apb(input w, input [21:0] a, input [7:0] d, input [3:0] st);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= st;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge ref_clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
        err_total = err_total + 1;
        report_and_stop;
      end
    end
  endtask

  task wr(input [21:0] a, input [7:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask

  task rd(input [21:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 8'h0, 4'h0);
      chk(rdat, exp);
    end
  endtask

  // Decoded outputs land within two edges after the write edge.
  task settle;
    begin
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask

  task tick;
    begin
      @(posedge ref_clk);
      rtc_fixed_cycle_interrupt <= 1'b1;
      @(posedge ref_clk);
      rtc_fixed_cycle_interrupt <= 1'b0;
      settle;
    end
  endtask

  task t_reset;
    begin
      chk(com_count, 32'h1);
      chk(pins_grounded, 32'h1);
      rd(A_PRI, 32'h0);
      rd(A_SEC, 32'h0);
      rd(A_OPT, 32'h0);
      $display("reset test done");
    end
  endtask

  // Every slice, bias and generator code, with output kept off throughout.
  task t_decode;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wr(A_PRI, {3'h0, i[2:0], 2'h0});
        settle;
        chk(com_count, COMS[i*4 +: 4]);
        chk(config_error, (i > 2) ? 32'h1 : 32'h0);
        rd(A_PRI, {27'h0, i[2:0], 2'h0});
      end
      for (i = 0; i < 4; i = i + 1) begin
        wr(A_PRI, {i[1:0], 1'b1, 3'h3, i[1:0]});
        settle;
        chk(bias_onehot, (i == 3) ? 32'h0 : 32'h1 << i);
        chk(gen_onehot, (i == 3) ? 32'h0 : 32'h1 << i);
        chk(waveform_b, 32'h1);
        chk(config_error, (i == 1) ? 32'h0 : 32'h1);
      end
      $display("decode test done");
    end
  endtask

  // Boost and pin bits change only while output is off, and the primary
  // register is written only then too. The reference is taken as settled
  // already, since a real settling wait is far beyond the run budget.
  task t_pins;
    integer i;
    begin
      wr(A_PRI, 8'h4D);
      wr(A_SEC, 8'h22);
      settle;
      chk(waveform_b, 32'h0);
      chk(config_error, 32'h0);
      chk({boost_circuit_run, boost_pin_init}, 32'h3);
      for (i = 0; i < 4; i = i + 1) begin
        wr(A_SEC, {i[1:0], 6'h22});
        settle;
        chk({pins_grounded, segments_deselected, display_active},
          {!i[0], i[0] & !i[1], i[0] & i[1]});
        chk(seen, (i == 3) ? 32'hA : 32'h0);
      end
      wr(A_SEC, 8'h22);
      wr(A_SEC, 8'h00);
      settle;
      chk(boost_circuit_run, 32'h0);
      $display("pin test done");
    end
  endtask

  task t_reserved;
    begin
      wr(A_SEC, 8'h3F);
      rd(A_SEC, 32'h3A);
      apb(1'b1, A_SEC, 8'h00, 4'h0);
      rd(A_SEC, 32'h3A);
      wr(A_SEC, 8'h00);
      wr(A_OPT, 8'hFF);
      rd(A_OPT, 32'h90);
      wr(A_OPT, 8'h00);
      apb(1'b0, 22'h10, 8'h0, 4'h0);
      chk(rerr, 32'h1);
      chk(rdat, 32'h0);
      $display("reserved test done");
    end
  endtask

  task t_nibble;
    begin
      wr(A_SEC, 8'h08);
      settle;
      chk(disp_nibble, 32'h5);
      wr(A_SEC, 8'h10);
      settle;
      chk(disp_nibble, 32'hA);
      tick;
      chk(disp_nibble, 32'h5);
      tick;
      chk(disp_nibble, 32'hA);
      wr(A_SEC, 8'h00);
      tick;
      chk(disp_nibble, 32'hA);
      $display("nibble test done");
    end
  endtask

  // Blink is already off before the low-speed source is chosen.
  task t_clock;
    begin
      wr(A_OPT, 8'h80);
      stop_or_halt <= 1'b1;
      cpu_on_subclk <= 1'b1;
      settle;
      chk(periph_subclk_en, 32'h0);
      cpu_on_subclk <= 1'b0;
      settle;
      chk(periph_subclk_en, 32'h1);
      wr(A_OPT, 8'h10);
      cpu_on_subclk <= 1'b1;
      settle;
      chk({periph_subclk_en, lcd_clk_lowspeed}, 32'h3);
      $display("clock test done");
    end
  endtask

  // Reset for five cycles, then each scenario in turn. No frames are
  // generated here, so the frame rate limits are left to the clock setup.
  // static is only ever paired with bias 00 above.
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_decode;
    t_pins;
    t_reserved;
    t_nibble;
    t_clock;
    report_and_stop;
  end
endmodule // test_lcd_drive_mode_control
